// File: ehlt_framer_model.sv
`timescale 1ns/1ps

module ehlt_framer_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // pacing
  input  wire logic       run,
  input  wire logic       slow,
  // slot stream
  output logic            slot_strobe,
  output logic [4:0]      slot_number,
  output logic [2:0]      slot_bit,
  output logic            frame_odd
);
  logic [8:0] pos;
  logic [1:0] gap;

  // one count wrap is an even and an odd frame; bit seven leaves first
  assign frame_odd   = pos[8];
  assign slot_number = pos[7:3];
  assign slot_bit    = ~pos[2:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_strobe <= 1'b0;
      pos         <= 9'h000;
      gap         <= 2'h0;
    end else begin
      pos         <= pos + {8'h00, slot_strobe};
      slot_strobe <= run && gap == 2'h0;
      gap         <= (gap != 2'h0) ? gap - 2'h1 : (run ? {slow, slow} : 2'h0);
    end
  end
endmodule : ehlt_framer_model

// File: ehlt_pkg.sv
package ehlt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // structure
  localparam int         LINKS       = 3;
  localparam int         FIFO_DEPTH  = 128;
  localparam int         PTR_W       = 7;
  localparam logic [7:0] FIFO_FULL   = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_LINK_SELECT = 10'h00A;
  localparam logic [9:0] IDX_LINK1_POS   = 10'h028;
  localparam logic [9:0] IDX_LINK1_MASK  = 10'h029;
  localparam logic [9:0] IDX_LINK2_POS   = 10'h02A;
  localparam logic [9:0] IDX_LINK2_MASK  = 10'h02B;
  localparam logic [9:0] IDX_LINK3_POS   = 10'h02C;
  localparam logic [9:0] IDX_LINK3_MASK  = 10'h02D;
  localparam logic [9:0] IDX_TX_CONTROL  = 10'h050;
  localparam logic [9:0] IDX_TX_UPPER    = 10'h051;
  localparam logic [9:0] IDX_TX_LOWER    = 10'h052;
  localparam logic [9:0] IDX_TX_IRQ_EN   = 10'h053;
  localparam logic [9:0] IDX_TX_STATUS   = 10'h054;
  localparam logic [9:0] IDX_TX_DATA     = 10'h055;
  localparam logic [9:0] IDX_TX_FILL     = 10'h056;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SEL_PATH_BIT   = 3;
  localparam int SEL_LINK_LSB   = 4;
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_FCS_BIT    = 1;
  localparam int CTL_EOM_BIT    = 3;
  localparam int CTL_CLEAR_BIT  = 6;
  localparam int POS_EVEN_BIT   = 7;
  localparam int POS_ODD_BIT    = 6;
  localparam int POS_S16_BIT    = 5;
  localparam int EV_FULL_BIT    = 3;
  localparam int EV_OVR_BIT     = 2;
  localparam int EV_UDR_BIT     = 1;
  localparam int EV_LOW_BIT     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] SEL_RESET   = 8'h00;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] CTL_STORED  = 8'h43;
  localparam logic [7:0] POS_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  localparam logic [3:0] IEN_RESET   = 4'h0;
  localparam logic [6:0] UPPER_RESET = 7'h40;
  localparam logic [6:0] LOWER_RESET = 7'h08;

  ////////////////////////////////////////////////////////////////////////////
  // line coding
  localparam logic [15:0] FLAG_WORD  = 16'h007E;
  localparam logic [15:0] ABORT_WORD = 16'h00FF;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [4:0]  BYTE_BITS  = 5'h08;
  localparam logic [4:0]  FCS_BITS   = 5'h10;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;
  localparam logic [4:0]  SLOT16     = 5'h10;

  typedef enum logic [1:0] {ST_FLAG, ST_DATA, ST_FCS, ST_ABORT} ehlt_state_e;

endpackage : ehlt_pkg

// File: ehlt_props.sv
`timescale 1ns/1ps

module ehlt_props (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // stream and interrupt
  input wire logic        slot_strobe,
  input wire logic        link_bit_valid,
  input wire logic        link_bit_data,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic take_rd;
  logic take_wr;
  assign take_rd = hsel & htrans[1] & hready & !hwrite;
  assign take_wr = hsel & htrans[1] & hready & hwrite;

  ////////////////////////////////////////////////////////////////////////////
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("error response seen");
  property p_read_wait;
    take_rd |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_write_nowait;
    take_wr |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("write stalled");
  property p_wait_cause;
    $fell(hreadyout) |-> $past(take_rd);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait state without read");
  // read data must not wander between reads
  property p_rdata_hold;
    $changed(hrdata) |-> !$past(hreadyout);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read");
  property p_valid_cause;
    link_bit_valid |-> $past(slot_strobe);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("link bit without strobe");
  property p_idle_ones;
    !link_bit_valid |-> link_bit_data;
  endproperty
  a_idle_ones: assert property (p_idle_ones)
    else $error("idle link data not one");
  // sticky status: only a write can drop the interrupt
  property p_irq_fall;
    $fell(irq) |-> $past(take_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without write");
endmodule : ehlt_props

// File: ehlt_transmitter.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps

module ehlt_transmitter
  import ehlt_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // framer transmit slot stream
  input  wire logic        slot_strobe,
  input  wire logic [4:0]  slot_number,
  input  wire logic [2:0]  slot_bit,
  input  wire logic        frame_odd,
  output logic             link_bit_valid,
  output logic             link_bit_data,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  logic                 accept;
  logic                 wr_pend;
  logic                 rd_pend;
  logic                 map_ok;
  logic [9:0]           acc_idx;
  logic [7:0]           wr_byte;
  logic [7:0]           link_select;
  logic [1:0]           tx_link_selector;
  logic                 path_position_select;
  logic                 link_ok;
  logic [31:0]          rd_value;
  logic [LINKS-1:0]     hit;
  logic [LINKS-1:0]     adv;
  logic [LINKS-1:0]     cur_bit;
  logic [LINKS-1:0][7:0] ctl_all;
  logic [LINKS-1:0][6:0] up_all;
  logic [LINKS-1:0][6:0] lo_all;
  logic [LINKS-1:0][3:0] ien_all;
  logic [LINKS-1:0][3:0] stat_all;
  logic [LINKS-1:0][7:0] pos_all;
  logic [LINKS-1:0][7:0] mask_all;
  logic [LINKS-1:0][7:0] fill_all;

  assign accept               = hsel && htrans[1] && hready;
  assign wr_byte              = hwdata[7:0];
  assign tx_link_selector     = link_select[SEL_LINK_LSB+1:SEL_LINK_LSB];
  assign path_position_select = link_select[SEL_PATH_BIT];
  assign link_ok              = (tx_link_selector != 2'h3);

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      map_ok    <= 1'b0;
      acc_idx   <= 10'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= accept && hwrite;
      rd_pend   <= accept && !hwrite;
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
      if (accept) begin
        acc_idx <= haddr[11:2];
        map_ok  <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend) begin
      hrdata <= rd_value;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_select <= SEL_RESET;
    end else if (wr_pend && map_ok && acc_idx == IDX_LINK_SELECT) begin
      link_select <= wr_byte;
    end
  end

  // unmapped and write-only locations read as zero
  always_comb begin
    rd_value = 32'h00000000;
    if (map_ok) begin
      case (acc_idx)
        IDX_LINK_SELECT: rd_value[7:0] = link_select;
        IDX_LINK1_POS:   rd_value[7:0] = path_position_select ? pos_all[0] : 8'h00;
        IDX_LINK1_MASK:  rd_value[7:0] = path_position_select ? mask_all[0] : 8'h00;
        IDX_LINK2_POS:   rd_value[7:0] = path_position_select ? pos_all[1] : 8'h00;
        IDX_LINK2_MASK:  rd_value[7:0] = path_position_select ? mask_all[1] : 8'h00;
        IDX_LINK3_POS:   rd_value[7:0] = path_position_select ? pos_all[2] : 8'h00;
        IDX_LINK3_MASK:  rd_value[7:0] = path_position_select ? mask_all[2] : 8'h00;
        IDX_TX_CONTROL:  rd_value[7:0] = link_ok ? ctl_all[tx_link_selector] : 8'h00;
        IDX_TX_UPPER:    rd_value[6:0] = link_ok ? up_all[tx_link_selector] : 7'h00;
        IDX_TX_LOWER:    rd_value[6:0] = link_ok ? lo_all[tx_link_selector] : 7'h00;
        IDX_TX_IRQ_EN:   rd_value[3:0] = link_ok ? ien_all[tx_link_selector] : 4'h0;
        IDX_TX_STATUS:   rd_value[3:0] = link_ok ? stat_all[tx_link_selector] : 4'h0;
        IDX_TX_FILL:     rd_value[7:0] = link_ok ? fill_all[tx_link_selector] : 8'h00;
        default:         rd_value = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per link: registers, fifo, serializer

  for (genvar l = 0; l < LINKS; l++) begin : g_link
    localparam logic [1:0] MY_SEL   = 2'(l);
    localparam logic [9:0] MY_POS   = 10'(int'(IDX_LINK1_POS) + 2 * l);
    localparam logic [9:0] MY_MASK  = 10'(int'(IDX_LINK1_MASK) + 2 * l);
    localparam logic [2:0] LOWER    = 3'((1 << l) - 1);

    logic [7:0]       ctl;
    logic [6:0]       upth;
    logic [6:0]       loth;
    logic [3:0]       ien;
    logic [3:0]       stat;
    logic [7:0]       pos;
    logic [7:0]       bmask;
    logic [7:0]       mem [FIFO_DEPTH];
    logic             tag [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [7:0]       count;
    logic [7:0]       pkt_cnt;
    ehlt_state_e      st;
    logic [15:0]      sh;
    logic [4:0]       bitcnt;
    logic [2:0]       ones;
    logic [15:0]      crc;
    logic             last;
    logic             sel_me;
    logic             w_reg;
    logic             w_ctl;
    logic             en;
    logic             clear;
    logic             push;
    logic             eom_mark;
    logic             stuff;
    logic             bit_last;
    logic             start_ok;
    logic             pop;
    logic             underrun;
    logic             crc_fb;
    logic [15:0]      crc_next;
    logic [4:0]       limit;
    logic [7:0]       head;
    logic             tag_head;
    logic             slot16_mode;
    logic [3:0]       ev;

    assign sel_me   = link_ok && (tx_link_selector == MY_SEL);
    assign w_reg    = wr_pend && map_ok && sel_me;
    assign w_ctl    = w_reg && acc_idx == IDX_TX_CONTROL;
    assign en       = ctl[CTL_ENABLE_BIT];
    assign clear    = ctl[CTL_CLEAR_BIT];
    assign head     = mem[rd_ptr];
    assign tag_head = tag[rd_ptr];

    // registers of this link
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctl   <= CTL_RESET;
        upth  <= UPPER_RESET;
        loth  <= LOWER_RESET;
        ien   <= IEN_RESET;
        pos   <= POS_RESET;
        bmask <= MASK_RESET;
      end else begin
        if (w_ctl) ctl <= wr_byte & CTL_STORED;
        if (w_reg && acc_idx == IDX_TX_UPPER) upth <= wr_byte[6:0];
        if (w_reg && acc_idx == IDX_TX_LOWER) loth <= wr_byte[6:0];
        if (w_reg && acc_idx == IDX_TX_IRQ_EN) ien <= wr_byte[3:0];
        // receive-side position writes belong to another block
        if (wr_pend && map_ok && path_position_select && acc_idx == MY_POS) begin
          pos <= wr_byte;
        end
        if (wr_pend && map_ok && path_position_select && acc_idx == MY_MASK) begin
          bmask <= wr_byte;
        end
      end
    end

    // sticky events, set beats the write-one clear
    assign ev[EV_FULL_BIT] = (count == FIFO_FULL);
    assign ev[EV_OVR_BIT]  = w_reg && acc_idx == IDX_TX_DATA && count == FIFO_FULL;
    assign ev[EV_UDR_BIT]  = underrun;
    assign ev[EV_LOW_BIT]  = en && (count < {1'b0, loth});

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stat <= 4'h0;
      end else if (w_reg && acc_idx == IDX_TX_STATUS) begin
        stat <= (stat & ~wr_byte[3:0]) | ev;
      end else begin
        stat <= stat | ev;
      end
    end

    // fifo
    assign push     = w_reg && acc_idx == IDX_TX_DATA && count != FIFO_FULL && !clear;
    assign eom_mark = w_ctl && wr_byte[CTL_EOM_BIT] && !wr_byte[CTL_CLEAR_BIT] && count != 8'h00
                      && !tag[PTR_W'(wr_ptr - 7'h01)];

    always_ff @(posedge hclk) begin
      if (push) begin
        mem[wr_ptr] <= wr_byte;
        tag[wr_ptr] <= 1'b0;
      end
      if (eom_mark) tag[PTR_W'(wr_ptr - 7'h01)] <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wr_ptr  <= 7'h00;
        rd_ptr  <= 7'h00;
        count   <= 8'h00;
        pkt_cnt <= 8'h00;
      end else if (clear) begin
        wr_ptr  <= 7'h00;
        rd_ptr  <= 7'h00;
        count   <= 8'h00;
        pkt_cnt <= 8'h00;
      end else begin
        if (push) wr_ptr <= wr_ptr + 7'h01;
        if (pop) rd_ptr <= rd_ptr + 7'h01;
        case ({push, pop})
          2'b10:   count <= count + 8'h01;
          2'b01:   count <= count - 8'h01;
          default: count <= count;
        endcase
        case ({eom_mark, pop && tag_head})
          2'b10:   pkt_cnt <= pkt_cnt + 8'h01;
          2'b01:   pkt_cnt <= pkt_cnt - 8'h01;
          default: pkt_cnt <= pkt_cnt;
        endcase
      end
    end

    // slot position match
    assign slot16_mode = pos[POS_S16_BIT] && !pos[POS_EVEN_BIT] && !pos[POS_ODD_BIT];
    // continuous form: each link drives only its own bit of the shared vector
    assign hit[l] = slot16_mode ? (slot_number == SLOT16)
                    : ((frame_odd ? pos[POS_ODD_BIT] : pos[POS_EVEN_BIT])
                       && slot_number == pos[4:0] && bmask[slot_bit]);
    // lower link number wins an overlapping slot
    assign adv[l] = slot_strobe && hit[l] && ((hit & LOWER) == 3'h0);

    // serializer
    always_comb begin
      crc_fb   = crc[0] ^ sh[0];
      crc_next = (crc >> 1) ^ (crc_fb ? CRC_POLY : 16'h0000);
    end
    assign limit    = (st == ST_FCS) ? FCS_BITS : BYTE_BITS;
    assign stuff    = (ones == STUFF_RUN);
    assign bit_last = adv[l] && en && !clear && !stuff && bitcnt == (limit - 5'h01);
    assign start_ok = count != 8'h00 && (pkt_cnt != 8'h00 || count >= {1'b0, upth});
    assign pop      = bit_last && ((st == ST_FLAG && start_ok)
                      || (st == ST_DATA && !last && count != 8'h00));
    assign underrun = bit_last && st == ST_DATA && !last && count == 8'h00;
    assign cur_bit[l] = (!en || clear) ? 1'b1 : (stuff ? 1'b0 : sh[0]);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st     <= ST_FLAG;
        sh     <= FLAG_WORD;
        bitcnt <= 5'h00;
        ones   <= 3'h0;
        crc    <= CRC_INIT;
        last   <= 1'b0;
      end else if (!en || clear) begin
        st     <= ST_FLAG;
        sh     <= FLAG_WORD;
        bitcnt <= 5'h00;
        ones   <= 3'h0;
      end else if (adv[l]) begin
        if (stuff) begin
          ones <= 3'h0;
        end else begin
          sh     <= sh >> 1;
          bitcnt <= bitcnt + 5'h01;
          if (st == ST_DATA || st == ST_FCS) ones <= sh[0] ? ones + 3'h1 : 3'h0;
          else ones <= 3'h0;
          if (st == ST_DATA) crc <= crc_next;
          if (bit_last) begin
            bitcnt <= 5'h00;
            case (st)
              ST_FLAG: begin
                if (start_ok) begin
                  st   <= ST_DATA;
                  sh   <= {8'h00, head};
                  last <= tag_head;
                  crc  <= CRC_INIT;
                end else begin
                  sh <= FLAG_WORD;
                end
              end
              ST_DATA: begin
                if (last && ctl[CTL_FCS_BIT]) begin
                  st <= ST_FCS;
                  sh <= ~crc_next;
                end else if (last) begin
                  st <= ST_FLAG;
                  sh <= FLAG_WORD;
                end else if (count != 8'h00) begin
                  sh   <= {8'h00, head};
                  last <= tag_head;
                end else begin
                  st <= ST_ABORT;
                  sh <= ABORT_WORD;
                end
              end
              default: begin
                st <= ST_FLAG;
                sh <= FLAG_WORD;
              end
            endcase
          end
        end
      end
    end

    assign ctl_all[l]  = ctl;
    assign up_all[l]   = upth;
    assign lo_all[l]   = loth;
    assign ien_all[l]  = ien;
    assign stat_all[l] = stat;
    assign pos_all[l]  = pos;
    assign mask_all[l] = bmask;
    assign fill_all[l] = count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stream output and interrupt

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_bit_valid <= 1'b0;
      link_bit_data  <= 1'b1;
    end else begin
      link_bit_valid <= |adv;
      link_bit_data  <= (|adv) ? |(adv & cur_bit) : 1'b1;
    end
  end

  // polled use simply leaves all enables at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |({stat_all[2], stat_all[1], stat_all[0]}
               & {ien_all[2], ien_all[1], ien_all[0]});
    end
  end

endmodule : ehlt_transmitter

// File: test_e1_hdlc_link_transmitter.sv
`timescale 1ns/1ps

module test_e1_hdlc_link_transmitter
  import ehlt_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, run, slow, rd_dp, sb_d;
  logic [31:0] haddr, hwdata, rnd, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, slot_bit;
  logic [4:0]  slot_number;
  logic        hreadyout, hresp, slot_strobe, frame_odd, link_bit_valid, link_bit_data, irq;
  logic [7:0]  cpos, cmsk, sr;
  logic [15:0] crc;
  logic [31:0] q_rd [$];
  logic        q_v [$];
  logic [7:0]  q_b [$];
  int          mismatches, n_tests, ones, cnt;
  logic [9:0]  ridx [7] = '{IDX_LINK_SELECT, IDX_TX_CONTROL, IDX_TX_UPPER, IDX_TX_LOWER,
                            IDX_TX_IRQ_EN, IDX_TX_FILL, 10'h3FF};
  logic [7:0]  rval [7] = '{8'h00, 8'h00, 8'h40, 8'h08, 8'h00, 8'h00, 8'h00};
  logic [7:0]  csel [4] = '{8'h08, 8'h08, 8'h28, 8'h58};
  logic [7:0]  cp [4]   = '{8'h20, 8'h40, 8'hD4, 8'hC4};
  logic [7:0]  cm [4]   = '{8'h00, 8'h1F, 8'hFF, 8'hFF};

  ehlt_transmitter dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slot_strobe(slot_strobe),
    .slot_number(slot_number), .slot_bit(slot_bit), .frame_odd(frame_odd),
    .link_bit_valid(link_bit_valid), .link_bit_data(link_bit_data), .irq(irq));
  ehlt_framer_model framer_u (
    .hclk(hclk), .hresetn(hresetn), .run(run), .slow(slow), .slot_strobe(slot_strobe),
    .slot_number(slot_number), .slot_bit(slot_bit), .frame_odd(frame_odd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction : crc_upd
  function automatic logic owns(input logic [4:0] s, input logic [2:0] b, input logic f);
    if (cpos[5] && cpos[7:6] == 2'b00) return s == 5'h10;
    return (f ? cpos[6] : cpos[7]) && s == cpos[4:0] && cmsk[b];
  endfunction : owns
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
                      input logic [7:0] e);
    if (!w) q_rd.push_back({24'h0, e});
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {20'h0, idx, 2'b00};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask : xfer
  task automatic strobes(input int n);
    rnd = xs(rnd);
    slow <= rnd[0];
    run  <= 1'b1;
    repeat (n * (rnd[0] ? 4 : 1)) @(posedge hclk);
    run  <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : strobes
  task automatic irq_is(input logic e);
    repeat (2) @(posedge hclk);
    compare({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  // receiver: flags reset framing, stuffed zeros and long runs of ones drop out
  task automatic rx_bit(input logic b);
    if (!b && ones >= 6) cnt = 0;
    else if (ones < 5) begin
      sr = {b, sr[7:1]};
      cnt++;
      if (cnt == 8) begin
        cnt = 0;
        if (q_b.size() == 0) compare({24'h0, sr}, 32'hFFFF_FFFF);
        else compare({24'h0, sr}, {24'h0, q_b.pop_front()});
      end
    end
    ones = b ? ones + 1 : 0;
  endtask : rx_bit

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) compare(hrdata, q_rd.pop_front());
    if (hreadyout) rd_dp <= hsel & htrans[1] & !hwrite;
    if (sb_d) compare({31'h0, link_bit_valid}, {31'h0, q_v.pop_front()});
    sb_d <= slot_strobe;
    if (slot_strobe) q_v.push_back(owns(slot_number, slot_bit, frame_odd));
    if (link_bit_valid) rx_bit(link_bit_data);
  end

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    logic [9:0] p;
    {hresetn, hsel, hwrite, run, slow, rd_dp, sb_d} = 7'h00;
    {haddr, hwdata, htrans, cpos, cmsk, sr, ones, cnt} = '0;
    hsize = 3'h2;
    rnd = 32'd40;
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) xfer(1'b0, ridx[i], 8'h00, rval[i]);
    xfer(1'b1, IDX_TX_UPPER, 8'h3F, 8'h00);
    xfer(1'b1, IDX_TX_LOWER, 8'h05, 8'h00);
    xfer(1'b0, IDX_TX_UPPER, 8'h00, 8'h3F);
    xfer(1'b0, IDX_TX_LOWER, 8'h00, 8'h05);
    // receive path selected: position writes must not land
    xfer(1'b1, IDX_LINK_SELECT, 8'h00, 8'h00);
    xfer(1'b1, IDX_LINK1_POS, 8'hC4, 8'h00);
    // positions only read back on the transmit path, so switch before looking
    xfer(1'b1, IDX_LINK_SELECT, 8'h08, 8'h00);
    xfer(1'b0, IDX_LINK1_POS, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      p = IDX_LINK1_POS + {7'h0, csel[i][5:4], 1'b0};
      xfer(1'b1, IDX_LINK_SELECT, csel[i], 8'h00);
      xfer(1'b1, p, cp[i], 8'h00);
      xfer(1'b1, p + 10'h1, cm[i], 8'h00);
      xfer(1'b0, p, 8'h00, cp[i]);
      cpos = cp[i];
      cmsk = cm[i];
      strobes(512);
      if (i < 3) begin
        xfer(1'b1, p, 8'h00, 8'h00);
        cpos = 8'h00;
      end
    end
    xfer(1'b1, IDX_TX_CONTROL, 8'hC3, 8'h00);
    xfer(1'b1, IDX_TX_CONTROL, 8'h83, 8'h00);
    for (int k = 0; k < 2; k++) begin
      crc = 16'hFFFF;
      for (int j = 0; j < 4; j++) begin
        rnd = xs(rnd);
        crc = crc_upd(crc, rnd[7:0]);
        q_b.push_back(rnd[7:0]);
        xfer(1'b1, IDX_TX_DATA, rnd[7:0], 8'h00);
      end
      if (k == 0) q_b.push_back(~crc[7:0]);
      if (k == 0) q_b.push_back(~crc[15:8]);
      xfer(1'b1, IDX_TX_CONTROL, k ? 8'h09 : 8'h8B, 8'h00);
      for (int t = 0; t < 40 && q_b.size() > 0; t++) strobes(256);
      compare(32'(q_b.size()), 32'h0);
      xfer(1'b1, IDX_TX_CONTROL, 8'h01, 8'h00);
    end
    // stopped link keeps the fifo filling so full and overrun can build up
    xfer(1'b1, IDX_TX_CONTROL, 8'h00, 8'h00);
    xfer(1'b1, IDX_TX_STATUS, 8'h0F, 8'h00);
    xfer(1'b1, IDX_TX_IRQ_EN, 8'h0F, 8'h00);
    for (int j = 0; j < 129; j++) xfer(1'b1, IDX_TX_DATA, 8'h55, 8'h00);
    xfer(1'b0, IDX_TX_FILL, 8'h00, 8'h80);
    xfer(1'b0, IDX_TX_STATUS, 8'h00, 8'h0C);
    irq_is(1'b1);
    xfer(1'b1, IDX_TX_IRQ_EN, 8'h00, 8'h00);
    irq_is(1'b0);
    xfer(1'b0, IDX_TX_STATUS, 8'h00, 8'h0C);
    xfer(1'b1, IDX_TX_IRQ_EN, 8'h03, 8'h00);
    irq_is(1'b0);
    xfer(1'b1, IDX_TX_IRQ_EN, 8'h0F, 8'h00);
    irq_is(1'b1);
    xfer(1'b1, IDX_TX_CONTROL, 8'h40, 8'h00);
    xfer(1'b1, IDX_TX_CONTROL, 8'h00, 8'h00);
    xfer(1'b0, IDX_TX_FILL, 8'h00, 8'h00);
    xfer(1'b1, IDX_TX_STATUS, 8'h0F, 8'h00);
    xfer(1'b0, IDX_TX_STATUS, 8'h00, 8'h00);
    irq_is(1'b0);
    repeat (4) @(posedge hclk);
    print_verdict();
  end
endmodule : test_e1_hdlc_link_transmitter

bind ehlt_transmitter ehlt_props chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .slot_strobe(slot_strobe), .link_bit_valid(link_bit_valid),
  .link_bit_data(link_bit_data), .irq(irq));
